// ---- logic/dcs_pkg.sv ----
// shared constants, types and crc function for the dual channel bus master
package dcs_pkg;

   localparam int         NCH           = 2;
   localparam int         DATA_W        = 16;
   localparam int         ENTRY_W       = 17;
   localparam int         FIFO_DEPTH    = 4;

   // register indices on the serial port
   localparam logic [2:0] REG_DATA_BASE = 3'h0;
   localparam logic [2:0] REG_STATUS    = 3'h4;
   localparam logic [2:0] REG_CTRL_BASE = 3'h5;
   localparam logic [2:0] REG_ENTRY_ERR = 3'h7;

   // channel control register fields
   localparam int         CTRL_MS       = 0;
   localparam int         CTRL_DIV      = 1;
   localparam int         CTRL_GAP      = 3;
   localparam int         CTRL_EN       = 7;
   localparam logic [7:0] CTRL_RESET    = 8'h00;

   // status register fields, one nibble per channel
   localparam int         ST_TFNF       = 0;
   localparam int         ST_RFNE       = 1;
   localparam int         ST_ER         = 2;
   localparam int         ST_OVF        = 3;
   localparam int         ST_STRIDE     = 4;

   // serial port
   localparam logic [2:0] SPI_LAST_BIT  = 3'h7;
   localparam logic [5:0] SYNC_RESET    = 6'h31;

   // framing
   localparam logic [3:0] CRC_INIT      = 4'ha;
   localparam logic [4:0] BITPTR_16     = 5'h13;
   localparam logic [4:0] BITPTR_8      = 5'h0b;
   localparam logic [5:0] GAP_MIN_BITS  = 6'h04;
   localparam logic [5:0] GAP_SAT       = 6'h3f;
   localparam logic [1:0] THIRD_LAST    = 2'h2;

   typedef enum logic [2:0] {ST_GAP, ST_DLY, ST_BITS, ST_RPUSH, ST_XPOP} dcs_eng_e;

   // crc over 8 or 16 data bits, msb first, x^4+1
   function automatic logic [3:0] dcs_crc4(input logic [15:0] d, input logic ms);
      logic [3:0] c;
      logic       fb;
      c  = CRC_INIT;
      fb = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         if (ms || i < 8)
         begin
            fb = c[3] ^ d[i];
            c  = {c[2:0], fb};
         end
      end
      return c;
   endfunction : dcs_crc4

endpackage : dcs_pkg

// ---- logic/dcs_fifo_if.sv ----
// push and pop handshake bundle for one fifo
`timescale 1ns/1ps
interface dcs_fifo_if #(parameter int W = 16);
   logic         push_valid;
   logic         push_ready;
   logic [W-1:0] push_data;
   logic         pop_valid;
   logic         pop_ready;
   logic [W-1:0] pop_data;
   logic         clear;

   modport store (input push_valid, push_data, pop_ready, clear, output push_ready, pop_valid, pop_data);
   modport user  (output push_valid, push_data, pop_ready, clear, input push_ready, pop_valid, pop_data);
endinterface : dcs_fifo_if

// ---- logic/dcs_fifo.sv ----
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module dcs_fifo #(
   parameter int W = 16,
   parameter int D = 4
) (
   // clock and reset
   input wire logic  clk_i,
   input wire logic  rst_i,
   // fifo ports
   dcs_fifo_if.store f
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);

   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic          push;
   logic          pop;

   // full ignores push, empty ignores pop
   assign f.push_ready = cnt_q != CW'(D);
   assign f.pop_valid  = cnt_q != '0;
   assign f.pop_data   = mem_q[rd_q];
   assign push         = f.push_valid && f.push_ready;
   assign pop          = f.pop_valid && f.pop_ready;

   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
      return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : wrap_inc

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else if (f.clear)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wrap_inc(wr_q);
         if (pop)
            rd_q <= wrap_inc(rd_q);
         if (push && !pop)
            cnt_q <= CW'(cnt_q + 1'b1);
         else if (pop && !push)
            cnt_q <= CW'(cnt_q - 1'b1);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < D; i++)
            mem_q[i] <= '0;
      end
      else if (push && !f.clear)
         mem_q[wr_q] <= f.push_data;
   end

endmodule : dcs_fifo

// ---- logic/dcs_master.sv ----
// two channel sensor bus master with serial register port
// Contract
// - host is mode zero master; device acts as mode zero slave.
// - chip select high releases data output; select, data, clock are inputs.
// - first byte is command: bit 7 write, low three bits set pointer.
// - command byte returns previously pointed register; zeros after reset.
// - pointer increments after each data byte, wrapping seven to zero.
// - read byte returns value sampled at prior transfer end; input ignored.
// - write bits land on rising clock; low byte complete pushes transmit fifo.
// - chip select fall latches receive heads and status for the burst.
// - writes to a full transmit buffer are ignored.
// - reads never show same-transfer writes; status stays as latched.
// - messages of 8 or 16 bits plus four crc bits.
// - frame falls first; msb starts one bit time later.
// - bit falls; low one third for 1, two thirds for 0.
// - return input sampled at end of each bit time.
// - frame returns high at end of last crc bit.
// - gap of 4, 8, 16 or 32 bit times between frames.
// - data sent msb first; received bits go to next free entry.
// - word arriving at full receive fifo sets overflow and is dropped.
// - entries carry crc error bit; not-empty set after stable push.
// - crc init 1010, polynomial x^4+1, sent after data lsb.
// - crc mismatch sets error flag on push; good word clears it.
// - control write in burst aborts transfer and empties both fifos.
// - transmit fifo holds four entries; pushes when full are ignored.
// - bit time is master clock divided by 3, 6, 12 or 24.
`timescale 1ns/1ps
module dcs_master
   import dcs_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // host serial port
   input  wire logic                  spi_clk_i,
   input  wire logic                  spi_cs_n_i,
   input  wire logic                  serial_in_pin_i,
   output logic                       spi_do_o,
   output logic                       spi_do_oe_o,
   // master clock for bit timing
   input  wire logic                  mclk_i,
   // physical layer channels
   output logic [dcs_pkg::NCH-1:0]    frame_output_o,
   output logic [dcs_pkg::NCH-1:0]    signal_output_o,
   input  wire logic [dcs_pkg::NCH-1:0] return_input_i
);
   import dcs_pkg::*;

   // input synchronisers
   logic [5:0]        raw;
   logic [5:0]        s1_q;
   logic [5:0]        s2_q;
   logic [5:0]        s3_q;
   logic [5:0]        flt_q;
   logic [5:0]        prev_q;
   logic              cs_act;
   logic              cs_fall;
   logic              sclk_rise;
   logic              sclk_fall;
   logic              di;
   logic              mtick;

   // serial port state
   logic [2:0]        ptr_q;
   logic [2:0]        next_ptr;
   logic [2:0]        bitcnt_q;
   logic              cmd_q;
   logic              wr_q;
   logic              first_q;
   logic [7:0]        ib_q;
   logic [7:0]        sh_q;
   logic              byte_end;
   logic [7:0]        hi_q   [NCH];
   logic [7:0]        lo_q   [NCH];
   logic [7:0]        ctrl_q [NCH];
   logic [7:0]        snap_st_q;
   logic [ENTRY_W-1:0] snap_w_q [NCH];
   logic [NCH-1:0]    push_pend_q;
   logic [NCH-1:0]    pop_pend_q;
   logic [NCH-1:0]    abort_q;

   // per channel status and fifo heads
   logic [7:0]        status_live;
   logic [ENTRY_W-1:0] rx_head [NCH];
   logic [NCH-1:0]    tfnf;
   logic [NCH-1:0]    rfne;
   logic [NCH-1:0]    er;
   logic [NCH-1:0]    ovf;

   assign raw = {return_input_i, mclk_i, serial_in_pin_i, spi_clk_i, spi_cs_n_i};

   // three flops; change counts once second and third agree
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1_q   <= SYNC_RESET;
         s2_q   <= SYNC_RESET;
         s3_q   <= SYNC_RESET;
         flt_q  <= SYNC_RESET;
         prev_q <= SYNC_RESET;
      end
      else
      begin
         s1_q   <= raw;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         flt_q  <= (s2_q & ~(s2_q ^ s3_q)) | (flt_q & (s2_q ^ s3_q));
         prev_q <= flt_q;
      end
   end

   assign cs_act    = ~flt_q[0];
   assign cs_fall   = prev_q[0] & ~flt_q[0];
   assign sclk_rise = cs_act & ~prev_q[1] & flt_q[1];
   assign sclk_fall = cs_act & prev_q[1] & ~flt_q[1];
   assign di        = flt_q[2];
   assign mtick     = ~prev_q[3] & flt_q[3];
   assign byte_end  = sclk_rise && bitcnt_q == '0;
   assign next_ptr  = cmd_q ? {ib_q[1:0], di} : 3'(ptr_q + 1'b1);

   // read mux over latched or live sources
   function automatic logic [7:0] rd_byte(input logic [2:0] idx, input logic [7:0] st,
                                          input logic [ENTRY_W-1:0] w0, input logic [ENTRY_W-1:0] w1,
                                          input logic [7:0] c0, input logic [7:0] c1);
      logic [7:0] r;
      r = 8'h00;
      case (idx)
         REG_DATA_BASE:            r = w0[15:8];
         3'(REG_DATA_BASE + 3'h1): r = w0[7:0];
         3'(REG_DATA_BASE + 3'h2): r = w1[15:8];
         3'(REG_DATA_BASE + 3'h3): r = w1[7:0];
         REG_STATUS:               r = st;
         REG_CTRL_BASE:            r = c0;
         3'(REG_CTRL_BASE + 3'h1): r = c1;
         REG_ENTRY_ERR:            r = {6'h00, w1[ENTRY_W-1], w0[ENTRY_W-1]};
         default:                  r = 8'h00;
      endcase
      return r;
   endfunction : rd_byte

   // bit counter and command capture
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bitcnt_q <= SPI_LAST_BIT;
         cmd_q    <= 1'b1;
         wr_q     <= 1'b0;
         ib_q     <= 8'h00;
      end
      else if (!cs_act)
      begin
         bitcnt_q <= SPI_LAST_BIT;
         cmd_q    <= 1'b1;
         wr_q     <= 1'b0;
      end
      else if (sclk_rise)
      begin
         ib_q     <= {ib_q[6:0], di};
         bitcnt_q <= 3'(bitcnt_q - 1'b1);
         if (bitcnt_q == '0)
         begin
            cmd_q <= 1'b0;
            if (cmd_q)
               wr_q <= ib_q[6];
         end
      end
   end

   // register pointer
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ptr_q <= REG_DATA_BASE;
      else if (byte_end)
         ptr_q <= next_ptr;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         first_q <= 1'b1;
      else if (byte_end)
         first_q <= 1'b0;
   end

   // output shifter; byte loaded ahead, writes never seen in same byte
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         sh_q <= 8'h00;
      else if (cs_fall)
         sh_q <= first_q ? 8'h00 : rd_byte(ptr_q, status_live, rx_head[0], rx_head[1],
                                           ctrl_q[0], ctrl_q[1]);
      else if (byte_end)
         sh_q <= rd_byte(next_ptr, snap_st_q, snap_w_q[0], snap_w_q[1],
                         ctrl_q[0], ctrl_q[1]);
      else if (sclk_fall && bitcnt_q != SPI_LAST_BIT)
         sh_q <= {sh_q[6:0], 1'b0};
   end

   assign spi_do_o    = sh_q[7];
   assign spi_do_oe_o = cs_act;

   // coherent snapshot at select fall
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         snap_st_q <= 8'h00;
         for (int c = 0; c < NCH; c++)
            snap_w_q[c] <= '0;
      end
      else if (cs_fall)
      begin
         snap_st_q <= status_live;
         for (int c = 0; c < NCH; c++)
            snap_w_q[c] <= rx_head[c];
      end
   end

   // bitwise register writes
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            hi_q[c]   <= 8'h00;
            lo_q[c]   <= 8'h00;
            ctrl_q[c] <= CTRL_RESET;
         end
      end
      else if (sclk_rise && !cmd_q && wr_q)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            if (ptr_q == 3'(REG_DATA_BASE + 3'(2 * c)))
               hi_q[c][bitcnt_q] <= di;
            if (ptr_q == 3'(REG_DATA_BASE + 3'(2 * c + 1)))
               lo_q[c][bitcnt_q] <= di;
            if (ptr_q == 3'(REG_CTRL_BASE + 3'(c)))
               ctrl_q[c][bitcnt_q] <= di;
         end
      end
   end

   // byte-end events: push, pop, abort
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         push_pend_q <= '0;
         pop_pend_q  <= '0;
         abort_q     <= '0;
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            push_pend_q[c] <= byte_end && !cmd_q && wr_q
                              && ptr_q == 3'(REG_DATA_BASE + 3'(2 * c + 1));
            pop_pend_q[c]  <= byte_end && !cmd_q && ptr_q == 3'(REG_DATA_BASE + 3'(2 * c + 1));
            abort_q[c]     <= byte_end && !cmd_q && wr_q
                              && ptr_q == 3'(REG_CTRL_BASE + 3'(c));
         end
      end
   end

   always_comb
   begin
      status_live = 8'h00;
      for (int c = 0; c < NCH; c++)
      begin
         status_live[c * ST_STRIDE + ST_TFNF] = tfnf[c];
         status_live[c * ST_STRIDE + ST_RFNE] = rfne[c];
         status_live[c * ST_STRIDE + ST_ER]   = er[c];
         status_live[c * ST_STRIDE + ST_OVF]  = ovf[c];
      end
   end

   // independent channel engines
   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      dcs_fifo_if #(.W(DATA_W))  tx_if ();
      dcs_fifo_if #(.W(ENTRY_W)) rx_if ();

      dcs_eng_e    state_q;
      logic [2:0]  sub_q;
      logic [1:0]  third_q;
      logic [4:0]  bitptr_q;
      logic [19:0] txsh_q;
      logic [19:0] rxsh_q;
      logic [5:0]  gap_q;
      logic        frame_q;
      logic        sig_q;
      logic        er_q;
      logic        ovf_q;
      logic        ms;
      logic        en;
      logic        kill;
      logic [2:0]  sub_last;
      logic [5:0]  gap_len;
      logic        third_tick;
      logic        bit_tick;
      logic        start;
      logic        last_bit;
      logic [15:0] rx_dat;
      logic        bad;

      assign ms         = ctrl_q[c][CTRL_MS];
      assign en         = ctrl_q[c][CTRL_EN];
      assign kill       = abort_q[c] | ~en;
      assign sub_last   = 3'((4'h1 << ctrl_q[c][CTRL_DIV +: 2]) - 4'h1);
      assign gap_len    = 6'(GAP_MIN_BITS << ctrl_q[c][CTRL_GAP +: 2]);
      assign third_tick = mtick && sub_q == sub_last;
      assign bit_tick   = third_tick && third_q == THIRD_LAST;
      assign start      = mtick && state_q == ST_GAP && en && tx_if.pop_valid && gap_q >= gap_len;
      assign last_bit   = state_q == ST_BITS && bit_tick && bitptr_q == '0;
      assign rx_dat     = ms ? rxsh_q[19:4] : {8'h00, rxsh_q[11:4]};
      assign bad        = rxsh_q[3:0] != dcs_crc4(rx_dat, ms);

      dcs_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_tx (
         .clk_i (clk_i),
         .rst_i (rst_i),
         .f     (tx_if)
      );
      dcs_fifo #(.W(ENTRY_W), .D(FIFO_DEPTH)) u_rx (
         .clk_i (clk_i),
         .rst_i (rst_i),
         .f     (rx_if)
      );

      assign tx_if.push_valid = push_pend_q[c];
      assign tx_if.push_data  = {hi_q[c], lo_q[c]};
      assign tx_if.pop_ready  = state_q == ST_XPOP;
      assign tx_if.clear      = kill;
      assign rx_if.push_valid = state_q == ST_RPUSH;
      assign rx_if.push_data  = {bad, rx_dat};
      assign rx_if.pop_ready  = pop_pend_q[c];
      assign rx_if.clear      = kill;

      assign rx_head[c] = rx_if.pop_valid ? rx_if.pop_data : '0;
      assign tfnf[c]    = tx_if.push_ready;
      assign rfne[c]    = rx_if.pop_valid;
      assign er[c]      = er_q;
      assign ovf[c]     = ovf_q;

      // thirds of a bit time from master clock ticks
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            sub_q   <= '0;
            third_q <= '0;
         end
         else if (start)
         begin
            sub_q   <= '0;
            third_q <= '0;
         end
         else if (mtick)
         begin
            if (sub_q == sub_last)
            begin
               sub_q   <= '0;
               third_q <= (third_q == THIRD_LAST) ? 2'h0 : 2'(third_q + 1'b1);
            end
            else
               sub_q <= 3'(sub_q + 1'b1);
         end
      end

      // inter-frame gap counter
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
            gap_q <= GAP_SAT;
         else if (last_bit)
            gap_q <= '0;
         else if (bit_tick && gap_q != GAP_SAT)
            gap_q <= 6'(gap_q + 1'b1);
      end

      // frame sequencer
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            state_q  <= ST_GAP;
            bitptr_q <= '0;
            txsh_q   <= '0;
            rxsh_q   <= '0;
         end
         else if (kill)
            state_q <= ST_GAP;
         else
         begin
            unique case (state_q)
               ST_GAP:
                  if (start)
                     state_q <= ST_DLY;
               ST_DLY:
                  if (bit_tick)
                  begin
                     state_q  <= ST_BITS;
                     bitptr_q <= ms ? BITPTR_16 : BITPTR_8;
                     rxsh_q   <= '0;
                     txsh_q   <= ms ? {tx_if.pop_data, dcs_crc4(tx_if.pop_data, 1'b1)}
                                    : {tx_if.pop_data[7:0], dcs_crc4(tx_if.pop_data, 1'b0), 8'h00};
                  end
               ST_BITS:
                  if (bit_tick)
                  begin
                     rxsh_q <= {rxsh_q[18:0], flt_q[4 + c]};
                     txsh_q <= {txsh_q[18:0], 1'b0};
                     if (bitptr_q == '0)
                        state_q <= ST_RPUSH;
                     else
                        bitptr_q <= 5'(bitptr_q - 1'b1);
                  end
               ST_RPUSH:
                  state_q <= ST_XPOP;
               ST_XPOP:
                  state_q <= ST_GAP;
            endcase
         end
      end

      // error and overflow flags
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            er_q  <= 1'b0;
            ovf_q <= 1'b0;
         end
         else if (state_q == ST_RPUSH && !kill)
         begin
            if (rx_if.push_ready)
               er_q <= bad;
            else
               ovf_q <= 1'b1;
         end
         else if (abort_q[c])
            ovf_q <= 1'b0;
      end

      // pin drivers
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            frame_q <= 1'b1;
            sig_q   <= 1'b1;
         end
         else
         begin
            frame_q <= !(state_q == ST_DLY || state_q == ST_BITS) || kill;
            if (state_q == ST_BITS && !kill)
               sig_q <= (third_q == 2'h0) ? 1'b0 : (third_q == 2'h1) ? txsh_q[19] : 1'b1;
            else
               sig_q <= 1'b1;
         end
      end

      assign frame_output_o[c]  = frame_q;
      assign signal_output_o[c] = sig_q;
   end

endmodule : dcs_master

// ---- test/dcs_phy_model.sv ----
// physical layer model answering on channel zero
`timescale 1ns/1ps
module dcs_phy_model (
   // channel pins and canned answer
   input  wire logic        frame_i,
   input  wire logic        signal_i,
   input  wire logic [11:0] resp_i,
   output logic             ret_o
);
   logic [11:0] sh;
   initial ret_o = 1'b0;
   always @(negedge frame_i) sh = resp_i;
   // new answer bit at each bit start, msb first
   always @(negedge signal_i)
   begin
      ret_o = sh[11];
      sh    = {sh[10:0], 1'b0};
   end
   // released line flips outside frames
   always @(posedge frame_i) ret_o = ~ret_o;
endmodule : dcs_phy_model

// ---- test/dcs_master_chk.sv ----
// pin assertions, bench runs divider three on a four clock master clock
`timescale 1ns/1ps
module dcs_master_chk
   import dcs_pkg::*;
(
   // clock and reset
   input wire logic           clk_i,
   input wire logic           rst_i,
   // host serial port
   input wire logic           spi_clk_i,
   input wire logic           spi_cs_n_i,
   input wire logic           serial_in_pin_i,
   input wire logic           spi_do_o,
   input wire logic           spi_do_oe_o,
   // channels
   input wire logic           mclk_i,
   input wire logic [NCH-1:0] frame_output_o,
   input wire logic [NCH-1:0] signal_output_o,
   input wire logic [NCH-1:0] return_input_i
);
   logic [8:0] lo_q;
   logic [8:0] hi_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // frame low and high lengths
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         lo_q <= 9'h000;
      else
         lo_q <= frame_output_o[0] ? 9'h000 : lo_q + 9'h001;
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         hi_q <= 9'h1ff;
      else if (!frame_output_o[0])
         hi_q <= 9'h000;
      else if (hi_q != 9'h1ff)
         hi_q <= hi_q + 9'h001;
   end
   a_oe_off_idle: assert property (spi_cs_n_i [*6] |-> !spi_do_oe_o) else $error("output on while idle");
   a_oe_on_sel: assert property (!spi_cs_n_i [*6] |-> spi_do_oe_o) else $error("output off while selected");
   a_sig_idle: assert property (frame_output_o[0] && $past(frame_output_o[0]) |-> signal_output_o[0])
      else $error("signal low outside frame");
   a_sig_in_frame: assert property ($fell(signal_output_o[0]) |-> !frame_output_o[0]) else $error("bit outside frame");
   a_first_bit: assert property ($fell(frame_output_o[0]) |-> signal_output_o[0] [*8] ##1 signal_output_o[0] [*4]
      ##1 !signal_output_o[0]) else $error("first bit delay wrong");
   a_bit_low: assert property ($fell(signal_output_o[0]) |-> !signal_output_o[0] [*4] ##1 (signal_output_o[0] or
      (!signal_output_o[0] [*4] ##1 signal_output_o[0]))) else $error("bit low time wrong");
   a_frame_len: assert property ($rose(frame_output_o[0]) |-> lo_q == 9'd156 || lo_q == 9'd252)
      else $error("frame length wrong");
   a_gap_min: assert property ($fell(frame_output_o[0]) |-> $past(hi_q) >= 9'd48) else $error("frame gap short");
endmodule : dcs_master_chk
bind dcs_master dcs_master_chk chk (.clk_i(clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk_i), .spi_cs_n_i(spi_cs_n_i),
   .serial_in_pin_i(serial_in_pin_i), .spi_do_o(spi_do_o), .spi_do_oe_o(spi_do_oe_o), .mclk_i(mclk_i),
   .frame_output_o(frame_output_o), .signal_output_o(signal_output_o), .return_input_i(return_input_i));

// ---- test/dcs_master_tb_top.sv ----
// register port and channel zero tests for the bus master
`timescale 1ns/1ps
module dcs_master_tb_top;
   import dcs_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        sck   = 1'b0;
   logic        cs_n  = 1'b1;
   logic        mosi  = 1'b0;
   logic        mclk  = 1'b0;
   logic        do_w, oe_w;
   logic [1:0]  fr, sg, ret;
   logic [11:0] resp  = 12'h000;
   logic [19:0] bits  = 20'h00000;
   int          failures = 0, tests_run = 0, lo = 0, nb = 0, dly = 0, d1 = 0;
   always #50 clk_i = ~clk_i;
   always #200 mclk = ~mclk;
   dcs_master uut (.clk_i(clk_i), .rst_i(rst_i), .spi_clk_i(sck), .spi_cs_n_i(cs_n), .serial_in_pin_i(mosi),
      .spi_do_o(do_w), .spi_do_oe_o(oe_w), .mclk_i(mclk), .frame_output_o(fr), .signal_output_o(sg),
      .return_input_i(ret));
   dcs_phy_model phy (.frame_i(fr[0]), .signal_i(sg[0]), .resp_i(resp), .ret_o(ret[0]));
   assign ret[1] = 1'b0;
   // decode bits from low time on channel zero
   always @(posedge clk_i)
   begin
      if (fr[0] === 1'b0)
      begin
         dly <= dly + 1;
         if (sg[0] === 1'b0 && lo == 0 && nb == 0)
            d1 <= dly;
         if (sg[0] === 1'b0)
            lo <= lo + 1;
         else if (lo > 0)
         begin
            bits <= {bits[18:0], lo < 6};
            nb   <= nb + 1;
            lo   <= 0;
         end
      end
      else
      begin
         dly <= 0;
         lo  <= 0;
      end
   end
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      if (failures == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   function automatic logic [3:0] crc8(input logic [7:0] d);
      logic [3:0] c;
      c = 4'ha;
      for (int i = 7; i >= 0; i--)
         c = {c[2:0], c[3] ^ d[i]};
      return c;
   endfunction : crc8
   // mode zero byte, host drives on low clock, both sample on rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         mosi = tx[i];
         repeat (8) @(posedge clk_i);
         #1 sck = 1'b1;
         rx[i] = do_w;
         repeat (8) @(posedge clk_i);
         #1 sck = 1'b0;
      end
   endtask : xfer
   task automatic burst(input logic [7:0] tx[$], input logic [7:0] ex[$]);
      logic [7:0] rx;
      @(posedge clk_i);
      #1 cs_n = 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      foreach (tx[i])
      begin
         xfer(tx[i], rx);
         check($sformatf("spi byte %0d", i), {8'h00, rx}, {8'h00, ex[i]});
      end
      repeat (8) @(posedge clk_i);
      #1 cs_n = 1'b1;
      repeat (12) @(posedge clk_i);
   endtask : burst
   task automatic frame_chk(input logic [19:0] exp, input logic [15:0] n);
      for (int k = 0; k < 3000 && fr[0] !== 1'b0; k++) @(posedge clk_i);
      for (int k = 0; k < 3000 && fr[0] !== 1'b1; k++) @(posedge clk_i);
      repeat (20) @(posedge clk_i);
      check("bit count", 16'(nb), n);
      check("frame bits", bits[15:0], exp[15:0]);
      check("frame top bits", {12'h000, bits[19:16]}, {12'h000, exp[19:16]});
      check("first bit delay", 16'(d1), 16'd12);
   endtask : frame_chk
   initial
   begin
      #3_000_000;
      failures++;
      end_of_test();
   end
   initial
   begin
      repeat (20) @(posedge clk_i);
      #1 rst_i = 1'b0;
      check("idle pins", {11'h000, oe_w, fr, sg}, 16'h000f);
      repeat (10) @(posedge clk_i);
      burst('{8'h04, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}, '{0, 8'h11, 0, 0, 0, 0, 0});
      burst('{8'h85, 8'h80}, '{0, 0});
      nb   = 0;
      bits = 20'h00000;
      resp = {8'hc3, crc8(8'hc3)};
      burst('{8'h80, 8'h00, 8'h5a}, '{0, 0, 0});
      frame_chk({8'h00, 8'h5a, crc8(8'h5a)}, 16'd12);
      burst('{8'h04, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}, '{0, 8'h13, 8'h80, 0, 0, 0, 8'hc3});
      nb   = 0;
      bits = 20'h00000;
      resp = 12'h000;
      burst('{8'h80, 8'h00, 8'h00}, '{0, 0, 0});
      frame_chk(20'h0000a, 16'd12);
      burst('{8'h04, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}, '{0, 8'h17, 8'h80, 0, 8'h01, 0, 0});
      burst('{8'h85, 8'h81}, '{0, 8'h80});
      nb   = 0;
      bits = 20'h00000;
      burst('{8'h80, 8'h00, 8'h00}, '{0, 0, 0});
      frame_chk(20'h0000a, 16'd20);
      end_of_test();
   end
endmodule : dcs_master_tb_top
